//--- rtl/sdc_bank_table.v
`timescale 1ns/1ps

module sdc_bank_table (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Lookup port
	input wire [2:0] rd_bank_i,
	output reg rd_open_o,
	output reg [15:0] rd_row_o,
	output wire any_open_o,
	// Update port
	input wire wr_en_i,
	input wire clr_all_i,
	input wire [2:0] wr_bank_i,
	input wire wr_open_i,
	input wire [15:0] wr_row_i
);

	reg [7:0] open_q;
	reg [15:0] row_mem [0:7];
	genvar g;

	// ****************************************
	// Open flags per bank
	// ****************************************
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_bank
			always @(posedge clock_i) begin
				if (rst_i || clr_all_i) begin
					open_q[g] <= 1'b0;
				end else if (wr_en_i && wr_bank_i == g) begin
					open_q[g] <= wr_open_i;
				end
			end
		end
	endgenerate

	// Row store, written on activate
	always @(posedge clock_i) begin
		if (wr_en_i && wr_open_i) begin
			row_mem[wr_bank_i] <= wr_row_i;
		end
	end

	// Registered lookup
	always @(posedge clock_i) begin
		if (rst_i) begin
			rd_open_o <= 1'b0;
			rd_row_o <= 16'h0000;
		end else begin
			rd_open_o <= open_q[rd_bank_i];
			rd_row_o <= row_mem[rd_bank_i];
		end
	end

	assign any_open_o = |open_q;

endmodule

//--- rtl/sdc_controller.v
// Overview of operation
// RL1 - Long calibration at init, optional later
// RL2 - Wait init or operational calibration window
// RL3 - Short calibration needs sixty-four clock window
// RL4 - Activate opens row in selected bank
// RL5 - Precharge bank before opening another row
// RL6 - Low column bits give burst start
// RL7 - Address bit ten selects auto precharge
// RL8 - Burst bit high eight beats, low four
// RL9 - Read burst always runs to completion
// RL10 - Read decode: select low, column strobe
// RL11 - Write decode: like read, write enable low
// RL12 - Byte mask high leaves byte untouched
// RL13 - Write only to bank with open row
// RL14 - Precharge bit ten high closes all
// RL15 - Reaccess bank only after precharge time
// RL16 - Precharge of idle bank is no-op
// RL17 - Activate idle bank before any access
// RL18 - Refresh ignores address, issued each time
// RL19 - Refresh average interval 7.8 or 3.9us
// RL20 - Only no-operation until refresh cycle ends
// RL21 - At most eight refreshes postponed
// RL22 - At most sixteen refreshes per two intervals
// RL23 - Commands sampled on rising link clock
// RL24 - Track open state and row per bank
`timescale 1ns/1ps
`include "sdc_defines.vh"

module sdc_controller (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// User request
	input wire req_valid_i,
	input wire req_write_i,
	input wire [2:0] req_bank_i,
	input wire [15:0] req_row_i,
	input wire [9:0] req_col_i,
	input wire req_chop_i,
	input wire req_autopre_i,
	input wire [63:0] wr_data_i,
	input wire [7:0] wr_mask_i,
	output wire req_ready_o,
	// Read return
	output reg [63:0] rd_data_o,
	output reg rd_valid_o,
	// Maintenance
	input wire hot_i,
	input wire sr_req_i,
	input wire zql_req_i,
	input wire zqs_req_i,
	output reg zq_ack_o,
	output reg init_done_o,
	output reg sr_active_o,
	// Memory pins
	output reg ck_o,
	output reg ck_n_o,
	output reg cke_o,
	output wire cs_n_o,
	output wire ras_n_o,
	output wire cas_n_o,
	output wire we_n_o,
	output reg [2:0] ba_o,
	output reg [15:0] a_o,
	output reg [7:0] dq_o,
	output reg dq_oe_o,
	output reg dm_o,
	input wire [7:0] dq_i
);

	localparam [2:0] ST_ZQI = 3'h0;
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_SR = 3'h2;
	localparam [15:0] TRP_C = `SDC_ROW_PRECHARGE_CYC;
	localparam [15:0] TRCD_C = `SDC_ACT_TO_ACCESS_CYC;
	localparam [15:0] REFRESH_CYCLE_TIME_C = `SDC_REFRESH_CYCLE_CYC;
	localparam [15:0] TXS_C = `SDC_SR_EXIT_CYC;
	localparam [15:0] AVERAGE_REFRESH_INTERVAL_C = `SDC_AVERAGE_REFRESH_INTERVAL_CYC;
	localparam [15:0] AVERAGE_REFRESH_INTERVAL_HOT_C = `SDC_HOT_REFRESH_INTERVAL_CYC;
	localparam [15:0] ZQINIT_C = `SDC_INIT_CALIBRATION_CYC;
	localparam [15:0] ZQOPER_C = `SDC_OPERATIONAL_CALIBRATION_CYC;
	localparam [15:0] SHORT_IMPEDANCE_CALIBRATION_C = `SDC_SHORT_CALIBRATION_CYC;
	localparam [15:0] GAP_C = `SDC_WRITE_RECOVERY_CYC + `SDC_ROW_PRECHARGE_CYC;
	localparam [15:0] WRLAT_C = `SDC_WR_LAT_CYC;
	localparam [15:0] RDLAT_C = `SDC_RD_LAT_CYC;
	localparam [15:0] HALF_C = `SDC_CK_HALF;

	// Column address with auto precharge and burst select
	function [15:0] col_addr;
		input [9:0] col;
		input autopre;
		input chop;
		begin
			col_addr = {3'h0, ~chop, 1'b0, autopre, col};
		end
	endfunction

	reg [2:0] div_q;
	reg [2:0] look_q;
	reg [2:0] state_q;
	reg [15:0] wait_q;
	reg [15:0] ri_q;
	reg [3:0] owed_q;
	reg [3:0] cmd_q;
	reg [7:0] s1_q, s2_q, s3_q, dq_s_q;
	reg eng_busy_q, eng_wr_q, eng_last_q;
	reg [15:0] eng_cnt_q;
	reg [2:0] eng_idx_q;
	reg [2:0] eng_end_q;
	reg [63:0] eng_data_q;
	reg [7:0] eng_mask_q;
	reg [63:0] rd_buf_q;
	wire bt_open, any_open;
	wire [15:0] bt_row;
	reg tb_en, tb_clr, tb_open;
	wire slot, ready, need_ref, maint, hit, access_go, ref_go;

	// ****************************************
	// Link clock divider and command slots
	// ****************************************
	// Pins change at the falling edge, device samples on the rising one
	always @(posedge clock_i) begin
		if (rst_i) begin
			div_q <= 3'h0;
			look_q <= 3'h0;
			ck_o <= 1'b1;
			ck_n_o <= 1'b0;
		end else begin
			div_q <= div_q + 3'h1;
			look_q <= req_bank_i;
			ck_o <= (div_q[2] == 1'b0); // [RL23]
			ck_n_o <= (div_q[2] == 1'b1);
		end
	end

	assign slot = (div_q == `SDC_SLOT_PH);
	// Table lookup lags one cycle, so wait until it shows the requested bank
	assign ready = slot && (wait_q == 16'h0000) && !eng_busy_q && (look_q == req_bank_i); // [RL24]
	assign need_ref = (owed_q == `SDC_POST_MAX); // [RL21]
	assign maint = need_ref || sr_req_i || zql_req_i || zqs_req_i || (owed_q != 4'h0 && !req_valid_i);
	assign hit = bt_open && (bt_row == req_row_i);
	assign access_go = ready && (state_q == ST_IDLE) && !maint && req_valid_i && hit; // [RL13]
	assign ref_go = ready && (state_q == ST_IDLE) && maint && !any_open && !sr_req_i
		&& (need_ref || !(zql_req_i || zqs_req_i)) && owed_q != 4'h0;
	assign req_ready_o = access_go;
	assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_q;

	// Per-bank open state and row
	sdc_bank_table u_bank_table (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.rd_bank_i(req_bank_i),
		.rd_open_o(bt_open),
		.rd_row_o(bt_row),
		.any_open_o(any_open),
		.wr_en_i(tb_en),
		.clr_all_i(tb_clr),
		.wr_bank_i(req_bank_i),
		.wr_open_i(tb_open),
		.wr_row_i(req_row_i)
	);

	// Bank table updates follow the issued command
	always @* begin
		tb_en = 1'b0;
		tb_clr = 1'b0;
		tb_open = 1'b0;
		if (ready && state_q == ST_IDLE) begin
			if (maint) begin
				tb_clr = any_open; // [RL24]
			end else if (req_valid_i) begin
				tb_en = !hit || req_autopre_i; // [RL24]
				tb_open = !bt_open;
			end
		end
	end

	// ****************************************
	// Refresh interval and posting count
	// ****************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			ri_q <= 16'h0000;
			owed_q <= 4'h0;
		end else begin
			if (state_q == ST_IDLE) begin
				ri_q <= (ri_q >= (hot_i ? AVERAGE_REFRESH_INTERVAL_HOT_C : AVERAGE_REFRESH_INTERVAL_C) - 16'h0001) ? 16'h0000 : ri_q + 16'h0001; // [RL19]
			end
			// Owed count never passes eight, so no more than 16 per two intervals
			if (state_q == ST_IDLE && ri_q == 16'h0000 && !ref_go && owed_q != `SDC_POST_MAX) begin
				owed_q <= owed_q + 4'h1; // [RL21] [RL22]
			end else if (ref_go && !(state_q == ST_IDLE && ri_q == 16'h0000)) begin
				owed_q <= owed_q - 4'h1; // [RL22]
			end
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= ST_ZQI;
			wait_q <= 16'h0000;
			cmd_q <= `SDC_CMD_DES;
			cke_o <= 1'b1;
			ba_o <= 3'h0;
			a_o <= 16'h0000;
			zq_ack_o <= 1'b0;
			init_done_o <= 1'b0;
			sr_active_o <= 1'b0;
		end else begin
			zq_ack_o <= 1'b0;
			if (wait_q != 16'h0000) begin
				wait_q <= wait_q - 16'h0001;
			end
			if (slot) begin
				cmd_q <= `SDC_CMD_NOP; // [RL20]
			end
			if (ready) begin
				case (state_q)
					ST_ZQI: begin
						cmd_q <= `SDC_CMD_ZQ; // [RL1]
						a_o <= 16'h0400;
						wait_q <= ZQINIT_C; // [RL2]
						state_q <= ST_IDLE;
					end
					ST_IDLE: begin
						init_done_o <= 1'b1;
						if (maint && any_open) begin
							cmd_q <= `SDC_CMD_PRE; // [RL14] [RL16]
							a_o <= 16'h0400;
							wait_q <= TRP_C; // [RL15]
						end else if (ref_go) begin
							cmd_q <= `SDC_CMD_REF; // [RL18]
							wait_q <= REFRESH_CYCLE_TIME_C; // [RL20]
						end else if (maint && sr_req_i) begin
							cmd_q <= `SDC_CMD_REF;
							cke_o <= 1'b0;
							sr_active_o <= 1'b1;
							state_q <= ST_SR; // [RL21]
						end else if (maint && zql_req_i) begin
							cmd_q <= `SDC_CMD_ZQ; // [RL1]
							a_o <= 16'h0400;
							wait_q <= ZQOPER_C; // [RL2]
							zq_ack_o <= 1'b1;
						end else if (maint && zqs_req_i) begin
							cmd_q <= `SDC_CMD_ZQ;
							a_o <= 16'h0000;
							wait_q <= SHORT_IMPEDANCE_CALIBRATION_C; // [RL3]
							zq_ack_o <= 1'b1;
						end else if (req_valid_i && !bt_open) begin
							cmd_q <= `SDC_CMD_ACT; // [RL4] [RL17]
							ba_o <= req_bank_i;
							a_o <= req_row_i;
							wait_q <= TRCD_C;
						end else if (req_valid_i && !hit) begin
							cmd_q <= `SDC_CMD_PRE; // [RL5] [RL14]
							ba_o <= req_bank_i;
							a_o <= 16'h0000;
							wait_q <= TRP_C; // [RL15]
						end else if (access_go) begin
							cmd_q <= req_write_i ? `SDC_CMD_WR : `SDC_CMD_RD; // [RL10] [RL11]
							ba_o <= req_bank_i;
							a_o <= col_addr(req_col_i, req_autopre_i, req_chop_i); // [RL6] [RL7] [RL8]
							wait_q <= req_autopre_i ? GAP_C : 16'h0000; // [RL15]
						end
					end
					ST_SR: begin
						if (!sr_req_i) begin
							cke_o <= 1'b1;
							sr_active_o <= 1'b0;
							wait_q <= TXS_C;
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Data pin sampling
	// ****************************************
	// A bit changes once the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_dq
			always @(posedge clock_i) begin
				if (rst_i) begin
					s1_q[g] <= 1'b0;
					s2_q[g] <= 1'b0;
					s3_q[g] <= 1'b0;
					dq_s_q[g] <= 1'b0;
				end else begin
					s1_q[g] <= dq_i[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) begin
						dq_s_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Burst data engine
	// ****************************************
	always @(posedge clock_i) begin
		if (rst_i) begin
			eng_busy_q <= 1'b0;
			eng_wr_q <= 1'b0;
			eng_last_q <= 1'b0;
			eng_cnt_q <= 16'h0000;
			eng_idx_q <= 3'h0;
			eng_end_q <= 3'h0;
			eng_data_q <= 64'h0;
			eng_mask_q <= 8'h00;
			rd_buf_q <= 64'h0;
			rd_data_o <= 64'h0;
			rd_valid_o <= 1'b0;
			dq_o <= 8'h00;
			dq_oe_o <= 1'b0;
			dm_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			if (access_go) begin
				eng_busy_q <= 1'b1;
				eng_wr_q <= req_write_i;
				eng_last_q <= 1'b0;
				eng_cnt_q <= req_write_i ? WRLAT_C : RDLAT_C;
				eng_idx_q <= 3'h0;
				eng_end_q <= req_chop_i ? 3'h3 : 3'h7; // [RL8]
				eng_data_q <= wr_data_i;
				eng_mask_q <= wr_mask_i;
			end else if (eng_busy_q && eng_cnt_q != 16'h0000) begin
				eng_cnt_q <= eng_cnt_q - 16'h0001;
			end else if (eng_busy_q && eng_last_q) begin
				eng_busy_q <= 1'b0;
				dq_oe_o <= 1'b0;
				rd_valid_o <= !eng_wr_q; // [RL9]
				rd_data_o <= rd_buf_q;
			end else if (eng_busy_q) begin
				// One beat per half link clock, burst never cut short
				if (eng_wr_q) begin
					dq_o <= eng_data_q[8 * eng_idx_q +: 8];
					dm_o <= eng_mask_q[eng_idx_q]; // [RL12]
					dq_oe_o <= 1'b1;
				end else begin
					rd_buf_q[8 * eng_idx_q +: 8] <= dq_s_q;
				end
				eng_idx_q <= eng_idx_q + 3'h1;
				eng_last_q <= (eng_idx_q == eng_end_q); // [RL9]
				eng_cnt_q <= HALF_C - 16'h0001;
			end
		end
	end

endmodule

//--- rtl/sdc_defines.vh
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// ****************************************
// Time base
// ****************************************
`define SDC_CLK_NS 10
`define SDC_CK_HALF 4
`define SDC_CK_PER 8
`define SDC_SLOT_PH 3'h4

// ****************************************
// Command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define SDC_CMD_NOP 4'h7
`define SDC_CMD_DES 4'hf
`define SDC_CMD_ACT 4'h3
`define SDC_CMD_RD 4'h5
`define SDC_CMD_WR 4'h4
`define SDC_CMD_PRE 4'h2
`define SDC_CMD_REF 4'h1
`define SDC_CMD_ZQ 4'h6

// ****************************************
// Address field positions
// ****************************************
`define SDC_AUTO_PRECHARGE_SELECT_BIT 10
`define SDC_BURST_SELECT_BIT 12

// ****************************************
// Timing, least times round up, longest round down
// ****************************************
`define SDC_ROW_PRECHARGE_TIME_NS 15
`define SDC_ROW_PRECHARGE_CYC ((`SDC_ROW_PRECHARGE_TIME_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_ACT_TO_ACCESS_NS 15
`define SDC_ACT_TO_ACCESS_CYC ((`SDC_ACT_TO_ACCESS_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_WRITE_RECOVERY_NS 15
`define SDC_WRITE_RECOVERY_CYC ((`SDC_WRITE_RECOVERY_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_REFRESH_CYCLE_TIME_NS 260
`define SDC_REFRESH_CYCLE_CYC ((`SDC_REFRESH_CYCLE_TIME_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_SR_EXIT_NS 270
`define SDC_SR_EXIT_CYC ((`SDC_SR_EXIT_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_AVERAGE_REFRESH_INTERVAL_NS 7800
`define SDC_AVERAGE_REFRESH_INTERVAL_CYC (`SDC_AVERAGE_REFRESH_INTERVAL_NS / `SDC_CLK_NS)
`define SDC_HOT_REFRESH_INTERVAL_NS 3900
`define SDC_HOT_REFRESH_INTERVAL_CYC (`SDC_HOT_REFRESH_INTERVAL_NS / `SDC_CLK_NS)
`define SDC_INIT_CALIBRATION_WINDOW_CK 512
`define SDC_INIT_CALIBRATION_CYC (`SDC_INIT_CALIBRATION_WINDOW_CK * `SDC_CK_PER)
`define SDC_OPERATIONAL_CALIBRATION_WINDOW_CK 256
`define SDC_OPERATIONAL_CALIBRATION_CYC (`SDC_OPERATIONAL_CALIBRATION_WINDOW_CK * `SDC_CK_PER)
`define SDC_SHORT_CALIBRATION_WINDOW_CK 64
`define SDC_SHORT_CALIBRATION_CYC (`SDC_SHORT_CALIBRATION_WINDOW_CK * `SDC_CK_PER)

// ****************************************
// Refresh posting and data latency
// ****************************************
`define SDC_POST_MAX 4'h8
`define SDC_WRITE_LATENCY_CK 5
`define SDC_READ_LATENCY_CK 6
`define SDC_WR_LAT_CYC (`SDC_CK_HALF + `SDC_WRITE_LATENCY_CK * `SDC_CK_PER - 2)
`define SDC_RD_LAT_CYC (`SDC_CK_HALF + `SDC_READ_LATENCY_CK * `SDC_CK_PER + 4)

`endif

//--- verification/sdc_checker.sv
`timescale 1ns/1ps
`include "sdc_defines.vh"
// ********
// Command pin checker
// ********
module sdc_checker (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Request side
	input wire req_valid_i,
	input wire req_write_i,
	input wire [2:0] req_bank_i,
	input wire [9:0] req_col_i,
	input wire req_chop_i,
	input wire req_autopre_i,
	input wire req_ready_o,
	// Status
	input wire zq_ack_o,
	input wire init_done_o,
	input wire sr_active_o,
	// Memory pins
	input wire cke_o,
	input wire ck_o,
	input wire ck_n_o,
	input wire cs_n_o,
	input wire ras_n_o,
	input wire cas_n_o,
	input wire we_n_o,
	input wire [2:0] ba_o,
	input wire [15:0] a_o
);
	reg [3:0] prev_q;
	reg [3:0] last_q;
	reg lbit_q;
	reg [12:0] gap_q;
	wire [3:0] cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
	wire start = cmd != prev_q && cmd != `SDC_CMD_NOP && cmd != `SDC_CMD_DES;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Last real command and its age
	always @(posedge clock_i) begin
		prev_q <= cmd;
		if (rst_i) begin
			last_q <= `SDC_CMD_NOP;
			lbit_q <= 1'b0;
			gap_q <= 13'h0;
		end else if (start) begin
			last_q <= cmd;
			lbit_q <= a_o[10];
			gap_q <= 13'h1;
		end else if (gap_q != 13'h1fff) begin
			gap_q <= gap_q + 13'h1;
		end
	end
	sequence rd_pins;
		cmd == `SDC_CMD_RD && ba_o == $past(req_bank_i) && a_o[9:0] == $past(req_col_i);
	endsequence
	sequence wr_pins;
		cmd == `SDC_CMD_WR && ba_o == $past(req_bank_i) && a_o[9:0] == $past(req_col_i);
	endsequence
	sequence flags_ok;
		a_o[10] == $past(req_autopre_i) && a_o[12] == !$past(req_chop_i);
	endsequence
	chk_rd_decode: assert property (req_ready_o && !req_write_i |=> rd_pins and flags_ok)
		else $error("read command pins wrong");
	chk_wr_decode: assert property (req_ready_o && req_write_i |=> wr_pins and flags_ok)
		else $error("write command pins wrong");
	chk_ready_pulse: assert property (req_ready_o |-> req_valid_i && init_done_o ##1 !req_ready_o)
		else $error("request taken wrongly");
	chk_cmd_stand: assert property (start |=> $stable(cmd) [*7])
		else $error("command not held one link period");
	chk_ref_quiet: assert property (start && last_q == `SDC_CMD_REF |-> gap_q >= 26)
		else $error("command inside refresh cycle");
	chk_zqs_window: assert property (start && last_q == `SDC_CMD_ZQ && !lbit_q |-> gap_q >= 512)
		else $error("command inside short calibration");
	chk_zql_window: assert property (start && last_q == `SDC_CMD_ZQ && lbit_q |-> gap_q >= 2048)
		else $error("command inside long calibration");
	chk_init_window: assert property ($rose(init_done_o) |-> last_q == `SDC_CMD_ZQ && gap_q >= 4096)
		else $error("init done too early");
	chk_init_zq: assert property (!init_done_o && start |-> cmd == `SDC_CMD_ZQ && a_o[10])
		else $error("init command not long calibration");
	chk_zq_ack: assert property (zq_ack_o |-> ##[0:1] cmd == `SDC_CMD_ZQ)
		else $error("calibration ack without command");
	chk_sr_entry: assert property ($rose(sr_active_o) |-> ##[0:1] (!cke_o && cmd == `SDC_CMD_REF))
		else $error("self refresh entry wrong");
	chk_ck_pair: assert property (ck_n_o == !ck_o)
		else $error("link clock pair not complementary");
	chk_cmd_setup: assert property ($rose(ck_o) |-> $stable(cmd))
		else $error("command changed at rising link clock");
endmodule
bind sdc_controller sdc_checker u_chk (.clock_i, .rst_i, .req_valid_i, .req_write_i, .req_bank_i, .req_col_i,
	.req_chop_i, .req_autopre_i, .req_ready_o, .zq_ack_o, .init_done_o, .sr_active_o, .cke_o, .ck_o, .ck_n_o, .cs_n_o,
	.ras_n_o, .cas_n_o, .we_n_o, .ba_o, .a_o);

//--- verification/sdc_dram_model.sv
`timescale 1ns/1ps
`include "sdc_defines.vh"
// ********
// Memory device model
// ********
module sdc_dram_model (
	// Link pins
	input wire ck_i,
	input wire cke_i,
	input wire cs_n_i,
	input wire ras_n_i,
	input wire cas_n_i,
	input wire we_n_i,
	input wire [2:0] ba_i,
	input wire [15:0] a_i,
	input wire [7:0] dq_i,
	input wire dq_oe_i,
	input wire dm_i,
	output reg [7:0] dq_o,
	// Status
	output integer viol_o,
	output integer n_ref_o
);
	reg [7:0] mem [int];
	reg open_q [0:7];
	reg [15:0] row_q [0:7];
	integer i;
	wire [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
	initial begin
		dq_o = 8'h5a;
		viol_o = 0;
		n_ref_o = 0;
		for (i = 0; i < 8; i = i + 1) open_q[i] = 1'b0;
	end
	// One burst, always runs to its end
	task automatic burst(input wr, input [28:0] base, input bl8);
		integer k;
		reg [2:0] j;
		begin
			repeat (wr ? `SDC_WRITE_LATENCY_CK : `SDC_READ_LATENCY_CK) @(posedge ck_i);
			#1;
			for (k = 0; k < (bl8 ? 8 : 4); k = k + 1) begin
				j = bl8 ? base[2:0] + k : {base[2], base[1:0] + k[1:0]};
				if (wr && dq_oe_i && !dm_i) mem[{base[28:3], j}] = dq_i;
				if (!wr) dq_o = mem.exists({base[28:3], j}) ? mem[{base[28:3], j}] : 8'h00;
				@(ck_i);
				#1;
			end
			if (!wr) dq_o = ~dq_o;
		end
	endtask
	// Decode at rising link clock
	always @(posedge ck_i) begin
		if (cke_i) begin
			case (cmd)
				`SDC_CMD_ACT: begin
					if (open_q[ba_i]) viol_o = viol_o + 1;
					open_q[ba_i] = 1'b1;
					row_q[ba_i] = a_i;
				end
				`SDC_CMD_RD, `SDC_CMD_WR: begin
					if (!open_q[ba_i]) viol_o = viol_o + 1;
					fork
						burst(!we_n_i, {ba_i, row_q[ba_i], a_i[9:0]}, a_i[12]);
					join_none
					if (a_i[10]) open_q[ba_i] = 1'b0;
				end
				`SDC_CMD_PRE: begin
					for (i = 0; i < 8; i = i + 1) if (a_i[10] || ba_i == i) open_q[i] = 1'b0;
				end
				`SDC_CMD_REF: begin
					for (i = 0; i < 8; i = i + 1) if (open_q[i]) viol_o = viol_o + 1;
					n_ref_o = n_ref_o + 1;
				end
				default: ;
			endcase
		end
	end
endmodule

//--- verification/tb_sdram_core_command_handling.sv
`timescale 1ns/1ps
`include "sdc_defines.vh"
// ********
// Bench top
// ********
module tb_sdram_core_command_handling;
	reg clock_i = 1'b0;
	reg rst_i = 1'b1;
	reg req_valid_i = 1'b0, req_write_i = 1'b0, req_chop_i = 1'b0, req_autopre_i = 1'b0;
	reg hot_i = 1'b0, sr_req_i = 1'b0, zql_req_i = 1'b0, zqs_req_i = 1'b0;
	reg [2:0] req_bank_i = 3'h0;
	reg [15:0] req_row_i = 16'h0;
	reg [9:0] req_col_i = 10'h0;
	reg [63:0] wr_data_i = 64'h0;
	reg [7:0] wr_mask_i = 8'h0;
	wire req_ready_o, rd_valid_o, zq_ack_o, init_done_o, sr_active_o, ck_o, cke_o, dq_oe_o, dm_o;
	wire cs_n_o, ras_n_o, cas_n_o, we_n_o;
	wire [63:0] rd_data_o;
	wire [2:0] ba_o;
	wire [15:0] a_o;
	wire [7:0] dq_o, dq_i;
	integer errors = 0, n_checks = 0, viol, n_ref, n, n0;
	reg [63:0] q;
	localparam [63:0] D1 = 64'h1122334455667788, D2 = 64'h99aabbccddeeff00, E = 64'h99aabbcc55667788;
	always #5 clock_i = ~clock_i;
	sdc_controller uut (.clock_i, .rst_i, .req_valid_i, .req_write_i, .req_bank_i, .req_row_i, .req_col_i,
		.req_chop_i, .req_autopre_i, .wr_data_i, .wr_mask_i, .req_ready_o, .rd_data_o, .rd_valid_o, .hot_i,
		.sr_req_i, .zql_req_i, .zqs_req_i, .zq_ack_o, .init_done_o, .sr_active_o, .ck_o, .ck_n_o(), .cke_o,
		.cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .ba_o, .a_o, .dq_o, .dq_oe_o, .dm_o, .dq_i);
	sdc_dram_model dev (.ck_i(ck_o), .cke_i(cke_o), .cs_n_i(cs_n_o), .ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
		.we_n_i(we_n_o), .ba_i(ba_o), .a_i(a_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .dm_i(dm_o), .dq_o(dq_i),
		.viol_o(viol), .n_ref_o(n_ref));
	task chk(input string nm, input [63:0] exp, input [63:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// Expected beats for a start column
	function [63:0] pick(input [63:0] e, input [9:0] c, input ch);
		integer k;
		reg [2:0] j;
		begin
			pick = 64'h0;
			for (k = 0; k < (ch ? 4 : 8); k = k + 1) begin
				j = ch ? {c[2], c[1:0] + k[1:0]} : c[2:0] + k[2:0];
				pick[8*k +: 8] = e[8*j +: 8];
			end
		end
	endfunction
	// One access, held until taken
	task acc(input w, input [2:0] b, input [15:0] r, input [9:0] c, input ch, input ap, input [63:0] d,
		input [7:0] m);
		begin
			@(posedge clock_i);
			req_valid_i <= 1'b1;
			req_write_i <= w;
			req_bank_i <= b;
			req_row_i <= r;
			req_col_i <= c;
			req_chop_i <= ch;
			req_autopre_i <= ap;
			wr_data_i <= d;
			wr_mask_i <= m;
			@(negedge clock_i);
			for (n = 0; n < 4000 && req_ready_o !== 1'b1; n = n + 1) @(negedge clock_i);
			chk("ready", 1, req_ready_o);
			@(posedge clock_i);
			req_valid_i <= 1'b0;
			for (n = 0; n < 400 && !w && rd_valid_o !== 1'b1; n = n + 1) @(negedge clock_i);
			if (!w) chk("rd_valid", 1, rd_valid_o);
			q = rd_data_o;
		end
	endtask
	task t_init;
		begin
			for (n = 0; n < 6000 && init_done_o !== 1'b1; n = n + 1) @(negedge clock_i);
			chk("init_done", 1, init_done_o);
			chk("init_len", 1, n >= 4096);
			$display("t_init done");
		end
	endtask
	task t_mask;
		begin
			acc(1, 3'h1, 16'h5, 10'h0, 0, 0, D1, 8'h00);
			acc(1, 3'h1, 16'h5, 10'h0, 0, 0, D2, 8'h0f);
			acc(0, 3'h1, 16'h5, 10'h0, 0, 0, 64'h0, 8'h0);
			chk("masked", E, q);
			acc(0, 3'h1, 16'h5, 10'h3, 0, 0, 64'h0, 8'h0);
			chk("col3", pick(E, 10'h3, 1'b0), q);
			acc(0, 3'h1, 16'h5, 10'h5, 1, 0, 64'h0, 8'h0);
			chk("chop5", pick(E, 10'h5, 1'b1), {32'h0, q[31:0]});
			$display("t_mask done");
		end
	endtask
	task t_miss;
		begin
			acc(1, 3'h1, 16'h9, 10'h0, 0, 0, ~D1, 8'h00);
			acc(0, 3'h1, 16'h5, 10'h0, 0, 1, 64'h0, 8'h0);
			chk("reopen", E, q);
			acc(0, 3'h1, 16'h9, 10'h0, 0, 0, 64'h0, 8'h0);
			chk("row9", ~D1, q);
			$display("t_miss done");
		end
	endtask
	task t_zq(input lng);
		begin
			@(posedge clock_i);
			zql_req_i <= lng;
			zqs_req_i <= !lng;
			for (n = 0; n < 3000 && zq_ack_o !== 1'b1; n = n + 1) @(negedge clock_i);
			chk("zq_ack", 1, zq_ack_o);
			@(posedge clock_i);
			zql_req_i <= 1'b0;
			zqs_req_i <= 1'b0;
			acc(0, 3'h1, 16'h9, 10'h0, 0, 0, 64'h0, 8'h0);
			chk("after_zq", ~D1, q);
			$display("t_zq done");
		end
	endtask
	task t_refresh;
		begin
			n0 = n_ref;
			repeat (2400) @(posedge clock_i);
			chk("ref_cool", 1, n_ref - n0 >= 2 && n_ref - n0 <= 16);
			hot_i <= 1'b1;
			n0 = n_ref;
			repeat (2400) @(posedge clock_i);
			chk("ref_hot", 1, n_ref - n0 >= 5 && n_ref - n0 <= 16);
			hot_i <= 1'b0;
			$display("t_refresh done");
		end
	endtask
	task t_sr;
		begin
			@(posedge clock_i);
			sr_req_i <= 1'b1;
			for (n = 0; n < 800 && sr_active_o !== 1'b1; n = n + 1) @(negedge clock_i);
			chk("sr_cke", 0, cke_o);
			repeat (800) @(posedge clock_i);
			sr_req_i <= 1'b0;
			for (n = 0; n < 100 && sr_active_o !== 1'b0; n = n + 1) @(negedge clock_i);
			repeat (40) @(negedge clock_i);
			chk("sr_exit", 1, cke_o);
			acc(0, 3'h1, 16'h9, 10'h0, 0, 0, 64'h0, 8'h0);
			chk("sr_keep", ~D1, q);
			$display("t_sr done");
		end
	endtask
	// Watchdog, nearly four times the expected run
	initial begin
		#500000;
		errors = errors + 1;
		print_verdict;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		t_init;
		t_mask;
		t_miss;
		t_zq(1'b1);
		t_zq(1'b0);
		t_refresh;
		t_sr;
		chk("viol", 0, viol);
		print_verdict;
	end
endmodule
